/* File: srof_defines.svh */
/*
 * Constants of the serial report output framer: character codes, frame layout,
 * bit rates, buffer depth and timing figures.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SROF_DEFINES_SVH
`define SROF_DEFINES_SVH

// Clock rate of the system clock.
`define SROF_CLK_HZ 20000000
`define SROF_CLK_KHZ 20000

// Transmission control characters.
`define SROF_CHR_STX 7'h02
`define SROF_CHR_ETX 7'h03
`define SROF_CHR_ACK 7'h06
`define SROF_CHR_NAK 7'h15
`define SROF_CHR_DC4 7'h14

// Character frame: start bit, data bits, parity bit, stop bit.
`define SROF_DATA_BITS 7
`define SROF_FRAME_BITS 10

// Selectable bit rates in bit/s and the codes that pick them.
`define SROF_BAUD_1200 1200
`define SROF_BAUD_2400 2400
`define SROF_BAUD_4800 4800
`define SROF_BAUD_9600 9600
`define SROF_BAUD_19200 19200
`define SROF_RATE_1200 3'h0
`define SROF_RATE_2400 3'h1
`define SROF_RATE_4800 3'h2
`define SROF_RATE_9600 3'h3
`define SROF_RATE_19200 3'h4
`define SROF_RATE_RESET `SROF_RATE_19200

// Record buffer depth in characters.
`define SROF_BUF_DEPTH 32

// Answer timeout in milliseconds and the retry limit in host mode.
`define SROF_ACK_TIMEOUT_MS 1000
`define SROF_MAX_RETRY 4'h3

`endif

/* File: srof_pkg.sv */
/*
 * Types of the serial report output framer: modes, states and state structs.
 * Assumes srof_defines.svh is on the include path.
 */
`include "srof_defines.svh"

package srof_pkg;

    // Transmission control modes.
    typedef enum logic [1:0] {
        SROF_MODE_RAW = 2'b00,
        SROF_MODE_CHECK = 2'b01,
        SROF_MODE_HOST = 2'b10
    } srof_mode_e;

    // Framer states, grouped by exchange phase.
    typedef enum logic [3:0] {
        SROF_ST_IDLE = 4'b0000,
        SROF_ST_CONN = 4'b0001,
        SROF_ST_STX = 4'b0010,
        SROF_ST_DATA = 4'b0011,
        SROF_ST_ETX = 4'b0100,
        SROF_ST_BCC = 4'b0101,
        SROF_ST_WAIT = 4'b0110,
        SROF_ST_DISC = 4'b0111
    } srof_state_e;

    typedef logic [6:0] srof_char_t;

    // Whole state of the framer.
    typedef struct packed {
        srof_state_e st;
        srof_mode_e mode;
        logic [2:0] rate;
        srof_char_t [`SROF_BUF_DEPTH-1:0] buf_;
        logic [5:0] count;
        logic [5:0] idx;
        srof_char_t bcc;
        logic [3:0] retry;
        logic [24:0] timer;
        logic rts;
        logic dtr;
        logic done;
        logic error;
    } srof_top_s;

    // Whole state of the character transmitter and receiver.
    typedef struct packed {
        logic tBusy;
        logic [9:0] tShift;
        logic [15:0] tCnt;
        logic [3:0] tBits;
        logic rBusy;
        logic [15:0] rCnt;
        logic [3:0] rBits;
        logic [7:0] rShift;
        logic rValid;
        srof_char_t rData;
    } srof_char_s;

endpackage : srof_pkg

/* File: srof_char_if.sv */
/*
 * Carrier between the framer controller and its character serial engine.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps

interface srof_char_if;
    import srof_pkg::*;

    logic [15:0] bitDiv;
    logic txValid;
    logic txReady;
    srof_char_t txData;
    logic rxEnable;
    logic rxValid;
    srof_char_t rxData;

    modport ctrl (output bitDiv, output txValid, input txReady, output txData,
                  output rxEnable, input rxValid, input rxData);
    modport phy (input bitDiv, input txValid, output txReady, input txData,
                 input rxEnable, output rxValid, output rxData);
endinterface : srof_char_if

/* File: srof_char_io.sv */
/*
 * Asynchronous character engine: sends and receives ten-bit characters with
 * seven data bits and even parity, one direction at a time.
 * Assumes rxd is synchronous to clock and bitDiv holds clocks per bit.
 */
`timescale 1ns/1ps

module srof_char_io
    import srof_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Controller side.
    srof_char_if.phy cio,
    // Serial line.
    input wire logic rxd,
    output logic txd
);

    srof_char_s q;
    srof_char_s next_q;

    // Handshake is combinational; the line never sends while receiving.
    assign cio.txReady = !q.tBusy && !q.rBusy;
    assign cio.rxValid = q.rValid;
    assign cio.rxData = q.rData;
    assign txd = q.tShift[0];

    // Next state of transmitter and receiver.
    always_comb
    begin
        next_q = q;
        next_q.rValid = 1'b0;
        if (!q.tBusy && !q.rBusy && cio.txValid)
        begin
            // Stop, even parity, data, start; sent from bit 0 upward.
            next_q.tShift = {1'b1, ^cio.txData, cio.txData, 1'b0};
            next_q.tBusy = 1'b1;
            next_q.tCnt = cio.bitDiv - 16'h0001;
            next_q.tBits = 4'h0;
        end
        else if (q.tBusy)
        begin
            if (q.tCnt == 16'h0000)
            begin
                next_q.tShift = {1'b1, q.tShift[9:1]};
                next_q.tCnt = cio.bitDiv - 16'h0001;
                next_q.tBits = q.tBits + 4'h1;
                if (q.tBits == 4'(`SROF_FRAME_BITS - 1))
                begin
                    next_q.tBusy = 1'b0;
                end
            end
            else
            begin
                next_q.tCnt = q.tCnt - 16'h0001;
            end
        end
        // Receiver listens only when enabled and the transmitter is quiet.
        if (!q.rBusy)
        begin
            if (cio.rxEnable && !q.tBusy && !rxd)
            begin
                next_q.rBusy = 1'b1;
                next_q.rCnt = {1'b0, cio.bitDiv[15:1]};
                next_q.rBits = 4'h0;
            end
        end
        else if (q.rCnt != 16'h0000)
        begin
            next_q.rCnt = q.rCnt - 16'h0001;
        end
        else
        begin
            next_q.rCnt = cio.bitDiv - 16'h0001;
            next_q.rBits = q.rBits + 4'h1;
            if (q.rBits == 4'h0)
            begin
                next_q.rBusy = !rxd; // A glitch on the start bit is dropped.
            end
            else if (q.rBits != 4'(`SROF_FRAME_BITS - 1))
            begin
                // Data bits and parity collect until the stop bit.
                next_q.rShift = {rxd, q.rShift[7:1]};
            end
            else
            begin
                // Ending at mid-stop keeps a low parity bit from posing as a start bit.
                next_q.rBusy = 1'b0;
                // Characters with bad parity are discarded.
                next_q.rValid = ~^q.rShift;
                next_q.rData = q.rShift[6:0];
            end
        end
    end

    // State register; the idle line is marking.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
            q.tShift <= 10'h3FF;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule : srof_char_io

/* File: srof_framer.sv */
/*
 * Serial report output framer: buffers one record and sends it over an
 * asynchronous link in raw, handshake-checked or framed host mode.
 * Assumes all inputs synchronous to clock; line levels are converted outside.
 */
// Notes on behaviour
// - Host mode wraps a record with STX before, ETX then BCC after.
// - BCC is even column parity over bytes after STX through ETX.
// - The link is transmit-only or half duplex, never both directions at once.
// - With handshake checking, send only while RTS, CTS, DSR and DTR are on.
// - Checked printer mode waits for CTS and DSR before sending data.
// - Unchecked printer mode ignores CTS and DSR.
// - Unchecked printer mode raises no error with nothing attached.
// - Only host mode uses control characters and error control.
// - Host exchange: connect, establish link, transfer, terminate, disconnect; the code has no link establishment, CONN goes straight to STX.
// - Printer modes skip link establishment and termination procedures.
// - Codes: STX 02, ETX 03, ACK 06, NAK 15, DC4 14.
// - Characters are start, seven data, even parity and stop bits.
// - Host mode resends the block on NAK or answer timeout.
// - Bit rate resets to 19200 and is selectable from 1200 to 19200.
`timescale 1ns/1ps

module srof_framer
    import srof_pkg::*;
#(
    parameter int unsigned ACK_TIMEOUT_CYCLES = `SROF_ACK_TIMEOUT_MS * `SROF_CLK_KHZ
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Configuration.
    input wire logic [1:0] modeSel,
    input wire logic [2:0] rateSel,
    input wire logic rateLoad,
    // Record stream.
    input wire logic recValid,
    input wire logic [6:0] recData,
    input wire logic recLast,
    output logic recReady,
    // Status.
    output logic busy,
    output logic sendDone,
    output logic sendError,
    // Serial link.
    output logic txd,
    input wire logic rxd,
    output logic rts,
    output logic dtr,
    input wire logic cts,
    input wire logic dsr
);

    localparam logic [24:0] TIMEOUT = 25'(ACK_TIMEOUT_CYCLES);
    localparam logic [5:0] LAST_SLOT = 6'(`SROF_BUF_DEPTH - 1);

    srof_top_s q;
    srof_top_s next_q;
    srof_char_if cio ();
    logic lineOk;
    logic sent;

    srof_char_io u_char (
        .clock(clock),
        .nrst(nrst),
        .cio(cio),
        .rxd(rxd),
        .txd(txd)
    );

    // Clocks per bit for the selected rate.
    always_comb
    begin
        case (q.rate)
            `SROF_RATE_1200: cio.bitDiv = 16'(`SROF_CLK_HZ / `SROF_BAUD_1200);
            `SROF_RATE_2400: cio.bitDiv = 16'(`SROF_CLK_HZ / `SROF_BAUD_2400);
            `SROF_RATE_4800: cio.bitDiv = 16'(`SROF_CLK_HZ / `SROF_BAUD_4800);
            `SROF_RATE_9600: cio.bitDiv = 16'(`SROF_CLK_HZ / `SROF_BAUD_9600);
            default: cio.bitDiv = 16'(`SROF_CLK_HZ / `SROF_BAUD_19200);
        endcase
    end

    // Handshake gate: raw mode sends blind, the others need all four lines on.
    assign lineOk = (q.mode == SROF_MODE_RAW) ? 1'b1
                  : (q.rts && q.dtr && cts && dsr);

    // Character offered to the engine in each sending state.
    always_comb
    begin
        cio.txValid = lineOk;
        case (q.st)
            SROF_ST_STX: cio.txData = `SROF_CHR_STX;
            SROF_ST_DATA: cio.txData = q.buf_[q.idx[4:0]];
            SROF_ST_ETX: cio.txData = `SROF_CHR_ETX;
            SROF_ST_BCC: cio.txData = q.bcc;
            default:
            begin
                cio.txData = 7'h00;
                cio.txValid = 1'b0;
            end
        endcase
    end

    assign sent = cio.txValid && cio.txReady;
    assign cio.rxEnable = (q.st == SROF_ST_WAIT);
    assign recReady = (q.st == SROF_ST_IDLE);
    assign busy = (q.st != SROF_ST_IDLE);
    assign rts = q.rts;
    assign dtr = q.dtr;
    assign sendDone = q.done;
    assign sendError = q.error;

    // Framer sequence.
    always_comb
    begin
        next_q = q;
        next_q.done = 1'b0;
        next_q.error = 1'b0;
        case (q.st)
            SROF_ST_IDLE:
            begin
                if (rateLoad)
                begin
                    next_q.rate = rateSel;
                end
                if (recValid)
                begin
                    next_q.buf_[q.count[4:0]] = recData;
                    next_q.count = q.count + 6'h01;
                    if (recLast || q.count == LAST_SLOT)
                    begin
                        next_q.mode = srof_mode_e'(modeSel);
                        next_q.rts = 1'b1;
                        next_q.retry = 4'h0;
                        next_q.st = SROF_ST_CONN;
                    end
                end
            end
            SROF_ST_CONN:
            begin
                // Line connection; printer modes go straight to the data.
                next_q.idx = 6'h00;
                if (q.mode == SROF_MODE_HOST)
                begin
                    next_q.st = SROF_ST_STX;
                end
                else
                begin
                    next_q.st = SROF_ST_DATA;
                end
            end
            SROF_ST_STX:
            begin
                if (sent)
                begin
                    next_q.bcc = 7'h00;
                    next_q.st = SROF_ST_DATA;
                end
            end
            SROF_ST_DATA:
            begin
                if (sent)
                begin
                    next_q.bcc = q.bcc ^ q.buf_[q.idx[4:0]];
                    next_q.idx = q.idx + 6'h01;
                    if (q.idx + 6'h01 == q.count)
                    begin
                        next_q.st = (q.mode == SROF_MODE_HOST) ? SROF_ST_ETX
                                  : SROF_ST_DISC;
                    end
                end
            end
            SROF_ST_ETX:
            begin
                if (sent)
                begin
                    next_q.bcc = q.bcc ^ `SROF_CHR_ETX;
                    next_q.st = SROF_ST_BCC;
                end
            end
            SROF_ST_BCC:
            begin
                if (sent)
                begin
                    next_q.timer = TIMEOUT;
                    next_q.st = SROF_ST_WAIT;
                end
            end
            SROF_ST_WAIT:
            begin
                // Termination: await the answer, resend on NAK or silence.
                next_q.timer = q.timer - 25'h000_0001;
                if (cio.rxValid && cio.rxData == `SROF_CHR_ACK)
                begin
                    next_q.done = 1'b1;
                    next_q.st = SROF_ST_DISC;
                end
                else if (cio.rxValid && cio.rxData == `SROF_CHR_DC4)
                begin
                    next_q.error = 1'b1; // Host refuses the block.
                    next_q.st = SROF_ST_DISC;
                end
                else if ((cio.rxValid && cio.rxData == `SROF_CHR_NAK) ||
                         q.timer == 25'h000_0000)
                begin
                    if (q.retry == `SROF_MAX_RETRY)
                    begin
                        next_q.error = 1'b1;
                        next_q.st = SROF_ST_DISC;
                    end
                    else
                    begin
                        next_q.retry = q.retry + 4'h1;
                        next_q.idx = 6'h00;
                        next_q.st = SROF_ST_STX;
                    end
                end
            end
            SROF_ST_DISC:
            begin
                // Disconnection; printer modes finish without any error path.
                if (cio.txReady)
                begin
                    // Host mode has already pulsed done on the acknowledge.
                    next_q.done = (q.mode != SROF_MODE_HOST);
                    next_q.rts = 1'b0;
                    next_q.count = 6'h00;
                    next_q.st = SROF_ST_IDLE;
                end
            end
            default:
            begin
                next_q.st = SROF_ST_IDLE;
            end
        endcase
    end

    // State register; DTR is held on from reset release.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
            q.rate <= `SROF_RATE_RESET;
        end
        else
        begin
            q <= next_q;
            q.dtr <= 1'b1;
        end
    end

endmodule : srof_framer

/* File: srof_framer_monitor.sv */
/*
 * Concurrent checks on the ports of the serial report output framer.
 * Assumes the framer runs at 19200 bit/s, so one bit lasts 1041 clocks.
 */
`timescale 1ns/1ps

module srof_framer_monitor
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Configuration.
    input wire logic [1:0] modeSel,
    input wire logic [2:0] rateSel,
    input wire logic rateLoad,
    // Record stream.
    input wire logic recValid,
    input wire logic [6:0] recData,
    input wire logic recLast,
    input wire logic recReady,
    // Status.
    input wire logic busy,
    input wire logic sendDone,
    input wire logic sendError,
    // Serial link.
    input wire logic txd,
    input wire logic rxd,
    input wire logic rts,
    input wire logic dtr,
    input wire logic cts,
    input wire logic dsr
);
    localparam int BIT_CLKS = 1041;
    logic [15:0] lowRun;
    logic prevTxd;

    // Counts how long txd has held its present level.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lowRun <= 16'h0000;
            prevTxd <= 1'b1;
        end
        else
        begin
            prevTxd <= txd;
            lowRun <= (txd != prevTxd) ? 16'h0001 : lowRun + 16'h0001;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Steps of a record and of a character on the line.
    sequence s_rec_end;
        recValid && recReady && recLast;
    endsequence
    sequence s_char_start;
        $fell(txd);
    endsequence

    property p_idle_line;
        !busy |-> txd && !rts;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("line active while idle");
    property p_ready_busy;
        recReady != busy;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready and busy agree");
    property p_rec_end;
        s_rec_end |=> busy && !recReady && rts;
    endproperty
    a_rec_end: assert property (p_rec_end) else $error("record end not taken");
    property p_dtr_on;
        $past(nrst) |-> dtr;
    endproperty
    a_dtr_on: assert property (p_dtr_on) else $error("terminal ready missing");
    property p_line_gate;
        s_char_start ##0 (modeSel != 2'b00) |-> $past(cts && dsr && rts && dtr);
    endproperty
    a_line_gate: assert property (p_line_gate) else $error("sent without handshake");
    property p_bit_len;
        $rose(txd) |-> (lowRun % BIT_CLKS) == 0;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
    property p_done_pulse;
        sendDone |=> !sendDone && !sendError;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
    property p_error_host;
        sendError |-> modeSel == 2'b10;
    endproperty
    a_error_host: assert property (p_error_host) else $error("error outside host mode");
endmodule : srof_framer_monitor

bind srof_framer srof_framer_monitor i_srof_framer_monitor (.clock(clock), .nrst(nrst),
    .modeSel(modeSel), .rateSel(rateSel), .rateLoad(rateLoad), .recValid(recValid),
    .recData(recData), .recLast(recLast), .recReady(recReady), .busy(busy),
    .sendDone(sendDone), .sendError(sendError), .txd(txd), .rxd(rxd), .rts(rts),
    .dtr(dtr), .cts(cts), .dsr(dsr));

/* File: srof_link_partner.sv */
/*
 * Model of the printer or host at the far end of the serial link.
 * Assumes one bit lasts BIT_CLKS clocks and the line idles at mark (high).
 */
`timescale 1ns/1ps

module srof_link_partner
#(
    parameter int BIT_CLKS = 1041
)
(
    // Clock.
    input wire logic clock,
    // Serial link.
    input wire logic txd,
    output logic rxd,
    // Reply control.
    input wire logic hostMode,
    input wire logic [6:0] replyCode,
    // Decoded characters.
    output logic gotValid,
    output logic [6:0] gotChar,
    output logic gotOk
);
    logic [9:0] frame;
    logic afterEnd;

    // Sends one character after a two-bit pause, with even parity.
    task automatic send_char(input logic [6:0] c);
        logic [9:0] f;
        f = {1'b1, ^c, c, 1'b0};
        repeat (2 * BIT_CLKS) @(posedge clock);
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
    endtask : send_char

    // Decodes each frame at mid-bit and answers a whole block in host mode.
    initial
    begin
        rxd = 1'b1;
        gotValid = 1'b0;
        gotChar = 7'h00;
        gotOk = 1'b0;
        afterEnd = 1'b0;
        forever
        begin
            @(negedge txd);
            repeat (BIT_CLKS / 2) @(posedge clock);
            for (int i = 0; i < 10; i++)
            begin
                frame[i] = txd;
                if (i < 9) repeat (BIT_CLKS) @(posedge clock);
            end
            gotChar = frame[7:1];
            gotOk = !frame[0] && frame[9] && !(^frame[8:1]);
            gotValid = 1'b1;
            @(posedge clock);
            gotValid = 1'b0;
            if (hostMode && afterEnd)
                send_char(replyCode);
            afterEnd = hostMode && (frame[7:1] == 7'h03);
        end
    end
endmodule : srof_link_partner

/* File: tb_top.sv */
/*
 * Self-checking bench of the framer in raw, checked and host modes.
 * Assumes the link partner model and the bound checker are compiled.
 */
`timescale 1ns/1ps

module tb_top;
    logic clock = 1'b0;
    logic nrst, rateLoad, recValid, recLast, cts, dsr, hostMode;
    logic [1:0] modeSel;
    logic [2:0] rateSel;
    logic [6:0] recData, gotChar, ch;
    logic recReady, busy, sendDone, sendError, txd, rxd, rts, dtr, gotValid, gotOk;
    logic [7:0] expQ[$];
    int n_errors = 0;
    int check_count = 0;
    int seed = 65890;
    int doneSeen = 0;
    int errSeen = 0;
    int rxCount = 0;

    // System clock of 50 ns.
    always #25 clock = ~clock;

    srof_framer #(.ACK_TIMEOUT_CYCLES(30000)) i_srof_framer (.clock(clock), .nrst(nrst),
        .modeSel(modeSel), .rateSel(rateSel), .rateLoad(rateLoad), .recValid(recValid),
        .recData(recData), .recLast(recLast), .recReady(recReady), .busy(busy),
        .sendDone(sendDone), .sendError(sendError), .txd(txd), .rxd(rxd), .rts(rts),
        .dtr(dtr), .cts(cts), .dsr(dsr));

    srof_link_partner i_srof_link_partner (.clock(clock), .txd(txd), .rxd(rxd),
        .hostMode(hostMode), .replyCode(7'h06), .gotValid(gotValid), .gotChar(gotChar),
        .gotOk(gotOk));

    // Compares one value and reports a mismatch.
    task check(input logic [7:0] seen, input logic [7:0] wanted);
        check_count++;
        if (seen !== wanted)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, wanted);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task report_and_stop;
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Offers a one-character record once the framer is idle.
    task send_rec(input logic [6:0] c);
        while (recReady !== 1'b1) @(negedge clock);
        recValid = 1'b1;
        recData = c;
        recLast = 1'b1;
        @(negedge clock);
        recValid = 1'b0;
        recLast = 1'b0;
        check({7'h00, recReady}, 8'h00);
    endtask : send_rec

    // Waits a bounded time for the next delivery pulse.
    task wait_done(input int limit);
        int d0;
        d0 = doneSeen;
        for (int i = 0; i < limit && doneSeen == d0; i++) @(negedge clock);
        check({7'h00, doneSeen != d0}, 8'h01);
    endtask : wait_done

    // Takes the oldest expected character for every decoded one.
    always @(negedge clock)
    begin
        if (gotValid === 1'b1)
        begin
            rxCount++;
            if (expQ.size() == 0)
                check({1'b0, gotChar}, 8'hff);
            else
                check({1'b0, gotChar}, expQ.pop_front());
            check({7'h00, gotOk}, 8'h01);
        end
        if (sendDone === 1'b1) doneSeen++;
        if (sendError === 1'b1) errSeen++;
    end

    // Main sequence: raw with nothing attached, checked with CTS late, host.
    initial
    begin
        nrst = 1'b0;
        modeSel = 2'b00;
        rateSel = 3'h4;
        rateLoad = 1'b0;
        recValid = 1'b0;
        recData = 7'h00;
        recLast = 1'b0;
        cts = 1'b0;
        dsr = 1'b0;
        hostMode = 1'b0;
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        rateLoad = 1'b1;
        @(negedge clock);
        rateLoad = 1'b0;
        ch = 7'($random(seed));
        expQ.push_back({1'b0, ch});
        send_rec(ch);
        wait_done(12000);
        modeSel = 2'b01;
        dsr = 1'b1;
        ch = 7'($random(seed));
        expQ.push_back({1'b0, ch});
        send_rec(ch);
        repeat (3000) @(negedge clock);
        check(8'(rxCount), 8'h01);
        cts = 1'b1;
        wait_done(14000);
        modeSel = 2'b10;
        hostMode = 1'b1;
        // Printable text only, so no data byte can pose as an end-of-text code.
        ch = {2'b01, 5'($random(seed))};
        expQ.push_back(8'h02);
        expQ.push_back({1'b0, ch});
        expQ.push_back(8'h03);
        expQ.push_back({1'b0, ch ^ 7'h03});
        send_rec(ch);
        wait_done(60000);
        check(8'(expQ.size()), 8'h00);
        check(8'(errSeen), 8'h00);
        report_and_stop();
    end

    // Cuts a hang short.
    initial
    begin
        repeat (100000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top
